// ### gearbox_pkg.sv
// shared constants and types for the input gearbox deserializer
package gearbox_pkg;

  // datapath geometry
  localparam int WORD_W     = 8;   // parallel word toward the core
  localparam int LANES      = 2;   // lane a and lane c serial paths
  localparam int HIST_W     = 16;  // capture history per lane, two words deep
  localparam int FIFO_DEPTH = 32;  // words buffered between stage two and three
  localparam int SEL_W      = 3;   // width of the alignment select
  localparam int CNT_W      = 4;   // width of the bit counter

  // lane indices inside the history array
  localparam int LANE_A = 0;
  localparam int LANE_C = 1;

  // field positions of the split one-to-four word
  localparam int NIB_W      = 4;
  localparam int HI_NIB_LSB = 4;   // lane a lands in bits 7..4
  localparam int LO_NIB_LSB = 0;   // lane c lands in bits 3..0

  // index of the last serial bit of a word in each mode
  localparam logic [CNT_W-1:0] LAST_BIT_SEVEN = 4'h6;
  localparam logic [CNT_W-1:0] LAST_BIT_EIGHT = 4'h7;
  localparam logic [CNT_W-1:0] LAST_BIT_FOUR  = 4'h3;

  // reset values
  localparam logic [WORD_W-1:0] WORD_RST = 8'h00;
  localparam logic [HIST_W-1:0] HIST_RST = 16'h0000;
  localparam logic [SEL_W-1:0]  SEL_RST  = 3'h0;
  localparam logic [CNT_W-1:0]  CNT_RST  = 4'h0;

  // gearing modes, one-hot
  typedef enum logic [2:0] {
    seven_bit_mode          = 3'b001,
    deser_one_to_eight_mode = 3'b010,
    deser_one_to_four_mode  = 3'b100
  } gear_mode_t;

endpackage : gearbox_pkg

// ### word_if.sv
// handshake carrier between stage two, the word fifo and stage three
interface word_if #(parameter int W = 8) ();
  logic         push_valid;
  logic         push_ready;
  logic [W-1:0] push_data;
  logic         pop_valid;
  logic         pop_ready;
  logic [W-1:0] pop_data;

  // gearbox side fills and drains
  modport writer (output push_valid, output push_data, output pop_ready,
                  input push_ready, input pop_valid, input pop_data);
  // fifo side
  modport buffer (input push_valid, input push_data, input pop_ready,
                  output push_ready, output pop_valid, output pop_data);
endinterface : word_if

// ### word_fifo.sv
// synchronous word fifo with valid/ready on both sides
module word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic ce,
  // fill and drain handshakes
  word_if.buffer   port_b
);
  // depth must be a power of two so the pointers wrap on their own
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  // honest flags straight from the occupancy count
  assign port_b.push_ready = (count_r != (AW+1)'(DEPTH));
  assign port_b.pop_valid  = (count_r != '0);
  assign port_b.pop_data   = mem_r[rd_ptr_r];
  assign push              = ce && port_b.push_valid && port_b.push_ready;
  assign pop               = ce && port_b.pop_valid && port_b.pop_ready;

  // storage array, no reset needed on the data itself
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= port_b.push_data;
    end
  end

  // pointers and count
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule : word_fifo

// ### input_gearbox_deserializer.sv
// input gearbox: samples serial lanes on both edge-clock edges, aligns and delivers parallel words
//
// Functional notes
// - in seven-bit mode the word sits on bits 6..0, in one-to-eight mode on all eight bits.
// - in split one-to-four mode lane a drives bits 7..4 and lane c drives bits 3..0.
// - the datapath is three register stages from serial input to parallel output.
// - stage one captures the serial input on both rising and falling edges of the edge clock.
// - stage two forms words under an update strobe and an alignment select from the control logic.
// - stage three registers the aligned word and presents it to the core on the system clock.
// - the serial input is the already delayed data, taken here as a lane input rather than a pad.
// - the gearbox runs as one seven-bit deserializer, one one-to-eight gearbox or two one-to-four gearboxes.
module input_gearbox_deserializer #(
  parameter int FIFO_DEPTH = gearbox_pkg::FIFO_DEPTH
) (
  // clock, reset, enable
  input  wire logic                         sys_clk,
  input  wire logic                         reset,
  input  wire logic                         ce,
  // serial link, asynchronous to sys_clk
  input  wire logic                         hs_edge_clock,
  input  wire logic                         ser_lane_a,
  input  wire logic                         ser_lane_c,
  // core control
  input  wire gearbox_pkg::gear_mode_t      gear_mode,
  input  wire logic                         word_align_request,
  // parallel word toward the core
  output logic [gearbox_pkg::WORD_W-1:0]    word_q,
  output logic                              word_valid,
  input  wire logic                         word_ready,
  output logic                              overrun
);
  localparam int LANES = gearbox_pkg::LANES;
  localparam int HW    = gearbox_pkg::HIST_W;
  localparam int WW    = gearbox_pkg::WORD_W;
  localparam int SW    = gearbox_pkg::SEL_W;
  localparam int CW    = gearbox_pkg::CNT_W;
  localparam int NW    = gearbox_pkg::NIB_W;

  // edge clock synchroniser: [0] first flop, [1] second, [2] history for edge finding
  logic [2:0]              clk_sync_r;
  logic                    link_edge;
  logic [LANES-1:0]        ser_pin;
  logic [1:0]              ser_sync_r [LANES];
  logic [HW-1:0]           hist_r     [LANES];
  logic [HW-1:0]           shifted    [LANES];

  // control block state
  gearbox_pkg::gear_mode_t mode_prev_r;
  logic                    mode_change;
  logic [CW-1:0]           last_bit;
  logic [CW-1:0]           bit_cnt_r;
  logic [SW-1:0]           align_sel_r;
  logic [SW-1:0]           align_sel_nxt;
  logic                    update_r;

  // stage two and three
  logic [WW-1:0]           st2_word_nxt;
  logic [WW-1:0]           st2_word_r;
  logic                    st2_valid_r;
  logic [WW-1:0]           word_q_r;
  logic                    word_valid_r;
  logic                    overrun_r;

  word_if #(.W(WW)) wbus ();

  assign ser_pin[gearbox_pkg::LANE_A] = ser_lane_a;
  assign ser_pin[gearbox_pkg::LANE_C] = ser_lane_c;

  // edge clock passes two flops before anything looks at it
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      clk_sync_r <= 3'h0;
    end else if (ce) begin
      clk_sync_r <= {clk_sync_r[1:0], hs_edge_clock};
    end
  end

  // either transition of the edge clock is a capture point
  assign link_edge = clk_sync_r[1] ^ clk_sync_r[2];

  // per lane: data synchroniser and stage one capture history
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    // data is delayed by the same two flops as the clock, keeping them in step
    always_ff @(posedge sys_clk) begin
      if (reset) begin
        ser_sync_r[g] <= 2'h0;
      end else if (ce) begin
        ser_sync_r[g] <= {ser_sync_r[g][0], ser_pin[g]};
      end
    end

    // newest bit enters at bit 0, older bits move up
    always_ff @(posedge sys_clk) begin
      if (reset) begin
        hist_r[g] <= gearbox_pkg::HIST_RST;
      end else if (ce && link_edge) begin
        hist_r[g] <= {hist_r[g][HW-2:0], ser_sync_r[g][1]};
      end
    end

    // the select drops the newest bits so the boundary moves one bit per step
    assign shifted[g] = hist_r[g] >> align_sel_r;
  end

  // word length per mode; an illegal code behaves as one-to-eight
  always_comb begin
    case (gear_mode)
      gearbox_pkg::seven_bit_mode:         last_bit = gearbox_pkg::LAST_BIT_SEVEN;
      gearbox_pkg::deser_one_to_four_mode: last_bit = gearbox_pkg::LAST_BIT_FOUR;
      default:                             last_bit = gearbox_pkg::LAST_BIT_EIGHT;
    endcase
  end

  // a mode switch restarts framing so no word mixes two geometries
  assign mode_change = (gear_mode != mode_prev_r);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mode_prev_r <= gearbox_pkg::deser_one_to_eight_mode;
    end else if (ce) begin
      mode_prev_r <= gear_mode;
    end
  end

  // next alignment select wraps at the word length
  always_comb begin
    if (align_sel_r >= last_bit[SW-1:0]) begin
      align_sel_nxt = gearbox_pkg::SEL_RST;
    end else begin
      align_sel_nxt = align_sel_r + 1'b1;
    end
  end

  // alignment select: one step per request from the core
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      align_sel_r <= gearbox_pkg::SEL_RST;
    end else if (ce) begin
      if (mode_change) begin
        align_sel_r <= gearbox_pkg::SEL_RST;
      end else if (word_align_request) begin
        align_sel_r <= align_sel_nxt;
      end
    end
  end

  // bit counter and update strobe; strobe comes the cycle after the last bit lands
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bit_cnt_r <= gearbox_pkg::CNT_RST;
      update_r  <= 1'b0;
    end else if (ce) begin
      update_r <= 1'b0;
      if (mode_change) begin
        bit_cnt_r <= gearbox_pkg::CNT_RST;
      end else if (link_edge) begin
        if (bit_cnt_r >= last_bit) begin
          bit_cnt_r <= gearbox_pkg::CNT_RST;
          update_r  <= 1'b1;
        end else begin
          bit_cnt_r <= bit_cnt_r + 1'b1;
        end
      end
    end
  end

  // stage two word layout per mode; the oldest bit of each lane field ends up in that field's top bit (bit 6 in seven-bit mode)
  always_comb begin
    case (gear_mode)
      gearbox_pkg::seven_bit_mode: begin
        st2_word_nxt = {1'b0, shifted[gearbox_pkg::LANE_A][WW-2:0]};
      end
      gearbox_pkg::deser_one_to_four_mode: begin
        st2_word_nxt = {shifted[gearbox_pkg::LANE_A][NW-1:0],
                        shifted[gearbox_pkg::LANE_C][NW-1:0]};
      end
      default: begin
        st2_word_nxt = shifted[gearbox_pkg::LANE_A][WW-1:0];
      end
    endcase
  end

  // stage two register; holds its word until the fifo takes it or the next update_r overwrites it
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st2_word_r  <= gearbox_pkg::WORD_RST;
      st2_valid_r <= 1'b0;
    end else if (ce) begin
      if (update_r) begin
        st2_word_r  <= st2_word_nxt;
        st2_valid_r <= 1'b1;
      end else if (wbus.push_ready) begin
        st2_valid_r <= 1'b0;
      end
    end
  end

  // the serial stream cannot be paused, so a word lost to a full fifo is flagged instead
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      overrun_r <= 1'b0;
    end else if (ce && update_r && st2_valid_r && !wbus.push_ready) begin
      overrun_r <= 1'b1;
    end
  end

  assign wbus.push_valid = st2_valid_r;
  assign wbus.push_data  = st2_word_r;
  assign wbus.pop_ready  = !word_valid_r || word_ready;

  word_fifo #(
    .WIDTH (WW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk (sys_clk),
    .reset   (reset),
    .ce      (ce),
    .port_b  (wbus.buffer)
  );

  // stage three: output register loads whenever it is empty or being drained
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      word_q_r     <= gearbox_pkg::WORD_RST;
      word_valid_r <= 1'b0;
    end else if (ce && wbus.pop_ready) begin
      word_valid_r <= wbus.pop_valid;
      if (wbus.pop_valid) begin
        word_q_r <= wbus.pop_data;
      end
    end
  end

  assign word_q     = word_q_r;
  assign word_valid = word_valid_r;
  assign overrun    = overrun_r;

  // checks on the datapath and the control block
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  chk_seven_layout: assert property (
    ce && update_r && gear_mode == gearbox_pkg::seven_bit_mode
    |=> st2_word_r[WW-1] == 1'b0 && st2_word_r[WW-2:0] == $past(shifted[gearbox_pkg::LANE_A][WW-2:0]))
    else $error("seven-bit word not on low seven bits");

  chk_eight_layout: assert property (
    ce && update_r && gear_mode == gearbox_pkg::deser_one_to_eight_mode
    |=> st2_word_r == $past(shifted[gearbox_pkg::LANE_A][WW-1:0]))
    else $error("eight-bit word does not use all bits");

  chk_lane_split: assert property (
    ce && update_r && gear_mode == gearbox_pkg::deser_one_to_four_mode
    |=> st2_word_r[WW-1:gearbox_pkg::HI_NIB_LSB] == $past(shifted[gearbox_pkg::LANE_A][NW-1:0])
        && st2_word_r[NW-1:gearbox_pkg::LO_NIB_LSB] == $past(shifted[gearbox_pkg::LANE_C][NW-1:0]))
    else $error("split lanes on wrong nibbles");

  chk_edge_capture: assert property (
    ce && link_edge |=> hist_r[gearbox_pkg::LANE_A][0] == $past(ser_sync_r[gearbox_pkg::LANE_A][1])
                        && hist_r[gearbox_pkg::LANE_A][HW-1:1] == $past(hist_r[gearbox_pkg::LANE_A][HW-2:0]))
    else $error("edge did not capture the synchronised bit");

  chk_update_timing: assert property (
    ce && link_edge && !mode_change && bit_cnt_r == last_bit
    |=> update_r && bit_cnt_r == gearbox_pkg::CNT_RST)
    else $error("update strobe missing after last bit");

  chk_stage_two_load: assert property (
    ce && update_r |=> st2_valid_r ##0 (wbus.push_valid && wbus.push_data == st2_word_r))
    else $error("stage two did not hold the new word");

  chk_output_hold: assert property (
    word_valid && !word_ready |=> word_valid && $stable(word_q))
    else $error("output word changed while stalled");

  chk_slip_step: assert property (
    ce && word_align_request && !mode_change
    |=> (align_sel_r == $past(align_sel_r) + 3'h1)
        || (align_sel_r == gearbox_pkg::SEL_RST && $past(align_sel_r) >= $past(last_bit[SW-1:0])))
    else $error("align request did not slip by one bit");

  chk_reset_clear: assert property (disable iff (1'b0)
    reset |=> bit_cnt_r == gearbox_pkg::CNT_RST && align_sel_r == gearbox_pkg::SEL_RST
              && !st2_valid_r && !word_valid && !overrun)
    else $error("reset left state behind");

  chk_lane_c_capture: assert property (
    ce && link_edge |=> hist_r[gearbox_pkg::LANE_C][0] == $past(ser_sync_r[gearbox_pkg::LANE_C][1])
                        && hist_r[gearbox_pkg::LANE_C][HW-1:1] == $past(hist_r[gearbox_pkg::LANE_C][HW-2:0]))
    else $error("lane c edge did not capture the synchronised bit");

  // a low enable must hold every stage, or a paused core would see words shift under it
  chk_ce_freeze: assert property (
    !ce |=> $stable(st2_word_r) && $stable(word_q) && $stable(bit_cnt_r) && $stable(align_sel_r))
    else $error("state moved while the clock enable was low");

  chk_output_load: assert property (
    ce && wbus.pop_ready && wbus.pop_valid |=> word_valid && word_q == $past(wbus.pop_data))
    else $error("output register did not take the fifo word");

endmodule : input_gearbox_deserializer

// ### core_sink.sv
// user core model: takes parallel words from the gearbox and can stall
module core_sink (
  // clock
  input  wire logic                          sys_clk,
  // word stream from the gearbox
  input  wire logic [gearbox_pkg::WORD_W-1:0] word_q,
  input  wire logic                          word_valid,
  output logic                               word_ready,
  // bench control
  input  wire logic                          stall
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [gearbox_pkg::WORD_W-1:0] got[$];

  // ready moves only off the sampling edge so the gearbox never sees it change mid-edge
  always @(negedge sys_clk) begin
    word_ready <= !stall;
  end

  // a word belongs to the core only on the edge that sees valid and ready together
  always @(posedge sys_clk) begin
    if (word_valid === 1'b1 && word_ready === 1'b1) begin
      got.push_back(word_q);
    end
  end
endmodule : core_sink

// ### tb_input_gearbox_deserializer.sv
// self-checking bench for the input gearbox deserializer
module tb_input_gearbox_deserializer;
  timeunit 1ns;
  timeprecision 100ps;

  logic                    sys_clk            = 1'b0;
  logic                    reset              = 1'b1;
  logic                    ce                 = 1'b1;
  logic                    hs_edge_clock      = 1'b0;
  logic                    ser_lane_a         = 1'b0;
  logic                    ser_lane_c         = 1'b0;
  logic                    word_align_request = 1'b0;
  logic                    stall              = 1'b0;
  gearbox_pkg::gear_mode_t gear_mode          = gearbox_pkg::deser_one_to_eight_mode;
  logic [7:0]              word_q;
  logic                    word_valid;
  logic                    word_ready;
  logic                    overrun;
  int                      miscompares        = 0;
  int                      check_count        = 0;

  // 100 MHz system clock
  always #5 sys_clk = ~sys_clk;

  // small fifo so that overflow is reached quickly
  input_gearbox_deserializer #(.FIFO_DEPTH(4)) u_input_gearbox_deserializer (
    .sys_clk            (sys_clk),
    .reset              (reset),
    .ce                 (ce),
    .hs_edge_clock      (hs_edge_clock),
    .ser_lane_a         (ser_lane_a),
    .ser_lane_c         (ser_lane_c),
    .gear_mode          (gear_mode),
    .word_align_request (word_align_request),
    .word_q             (word_q),
    .word_valid         (word_valid),
    .word_ready         (word_ready),
    .overrun            (overrun)
  );

  core_sink u_core_sink (
    .sys_clk    (sys_clk),
    .word_q     (word_q),
    .word_valid (word_valid),
    .word_ready (word_ready),
    .stall      (stall)
  );

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    if (miscompares == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  // reset with the new mode already set, then let the edge detector fill its history
  task automatic restart(input gearbox_pkg::gear_mode_t m);
    // entered on a falling edge or at time zero, so reset spans exactly two rising edges
    reset     = 1'b1;
    gear_mode = m;
    stall     = 1'b0;
    repeat (2) @(negedge sys_clk);
    reset = 1'b0;
    u_core_sink.got.delete();
    repeat (3) @(negedge sys_clk);
  endtask : restart

  // one frame, oldest bit first; data moves half way between edge-clock transitions
  task automatic send(input logic [7:0] a, input logic [7:0] c, input int n);
    #3;
    for (int i = n - 1; i >= 0; i--) begin
      ser_lane_a = a[i];
      ser_lane_c = c[i];
      #20;
      hs_edge_clock = ~hs_edge_clock;
      #20;
    end
    // idle lanes flip so a stale bit cannot pass for fresh data
    ser_lane_a = ~ser_lane_a;
    ser_lane_c = ~ser_lane_c;
  endtask : send

  task automatic wait_words(input int n);
    int k;
    k = 0;
    while (u_core_sink.got.size() < n && k < 2000) begin
      @(negedge sys_clk);
      k++;
    end
    if (k == 2000) begin
      miscompares++;
      $display("BAD word count expected %0d seen %0d", n, u_core_sink.got.size());
      end_of_test();
    end
  endtask : wait_words

  // one-to-eight, two frames back to back
  task automatic t_eight();
    restart(gearbox_pkg::deser_one_to_eight_mode);
    send(8'ha5, 8'h00, 8);
    send(8'h3c, 8'h00, 8);
    wait_words(2);
    check("eight word0", u_core_sink.got[0], 8'ha5);
    check("eight word1", u_core_sink.got[1], 8'h3c);
  endtask : t_eight

  // seven-bit words sit on the low seven bits, bit 7 reads zero
  task automatic t_seven();
    restart(gearbox_pkg::seven_bit_mode);
    send(8'h2b, 8'h00, 7);
    send(8'h55, 8'h00, 7);
    wait_words(2);
    check("seven word0", u_core_sink.got[0], 8'h2b);
    check("seven word1", u_core_sink.got[1], 8'h55);
  endtask : t_seven

  // split mode: lane a nibble on top, lane c nibble below; a frame sent with the enable low leaves no trace
  task automatic t_split();
    restart(gearbox_pkg::deser_one_to_four_mode);
    ce = 1'b0;
    send(8'h0f, 8'h0f, 4);
    @(negedge sys_clk);
    ce = 1'b1;
    send(8'h0a, 8'h05, 4);
    send(8'h03, 8'h0c, 4);
    wait_words(2);
    check("split word0", u_core_sink.got[0], 8'ha5);
    check("split word1", u_core_sink.got[1], 8'h3c);
    repeat (20) @(negedge sys_clk);
    check("split count", 8'(u_core_sink.got.size()), 8'h02);
  endtask : t_split

  // ten slip requests back to back wrap the select once and leave a two-bit slip
  task automatic t_align();
    restart(gearbox_pkg::deser_one_to_eight_mode);
    word_align_request = 1'b1;
    repeat (10) @(negedge sys_clk);
    word_align_request = 1'b0;
    send(8'ha5, 8'h00, 8);
    send(8'h3c, 8'h00, 8);
    wait_words(2);
    check("slip word0", u_core_sink.got[0], 8'h29);
    check("slip word1", u_core_sink.got[1], 8'h4f);
  endtask : t_align

  // core stalls until the fifo overflows, then drains; finally reset clears a held word
  task automatic t_overrun();
    restart(gearbox_pkg::deser_one_to_eight_mode);
    stall = 1'b1;
    for (int w = 0; w < 8; w++) begin
      send(8'(8'h11 * (w + 1)), 8'h00, 8);
    end
    repeat (12) @(negedge sys_clk);
    check("overrun flag", {7'h00, overrun}, 8'h01);
    check("stalled word", word_q, 8'h11);
    stall = 1'b0;
    wait_words(6);
    for (int i = 0; i < 5; i++) begin
      check("drained word", u_core_sink.got[i], 8'(8'h11 * (i + 1)));
    end
    check("drained last", u_core_sink.got[5], 8'h88);
    check("drained count", 8'(u_core_sink.got.size()), 8'h06);
    stall = 1'b1;
    send(8'h77, 8'h00, 8);
    repeat (12) @(negedge sys_clk);
    check("held valid", {7'h00, word_valid}, 8'h01);
    reset = 1'b1;
    @(negedge sys_clk);
    check("reset valid", {7'h00, word_valid}, 8'h00);
    check("reset word", word_q, 8'h00);
    check("reset overrun", {7'h00, overrun}, 8'h00);
    reset = 1'b0;
  endtask : t_overrun

  // main sequence
  initial begin
    t_eight();
    t_seven();
    t_split();
    t_align();
    t_overrun();
    end_of_test();
  end
endmodule : tb_input_gearbox_deserializer
